// ---- hw/stac_regs.sv ----
// Register bank for address table search readout and VLAN table commands.
// Assumes a byte-wide register port on one core clock, and a search engine
// that offers an entry only while search_take_out is high.
// Overview of operation
// RULE1: Two independent four-byte search result slots sit at 68h and 78h.
// RULE2: Each slot carries the found entry's valid flag in bit 16.
// RULE3: Each slot carries the found entry's static flag in bit 15.
// RULE4: Each slot carries the found entry's age flag in bit 14.
// RULE5: Each slot carries the three-bit traffic class in bits 13 to 11.
// RULE6: Reading a slot clears it and lets the search find the next entry.
// RULE7: Multicast entries show a port map in bits 8 to 0, bit 8 the CPU.
// RULE8: Unicast entries show the port number in bits 3 to 0, 8 to 4 zero.
// RULE9: Software writes go bit 7 to start a VLAN op; hardware clears it.
// RULE10: Op field 00 writes, 01 reads, 10 clears the table, 11 reserved.
// RULE11: Reads and writes address the VLAN table by the 12-bit index.
// RULE12: Search start bit 7 is set by software and cleared at search end.
// RULE13: Search ready bit 0 is set on a find and drops once it is read; the code holds it set while either slot is full.
// RULE14: A companion word holds the VLAN id in 59:48 and MAC in 47:0.
// RULE15: Software waits for go to read 0 before a new VLAN command.
// RULE16: Op 11 leaves the table untouched and still clears go.
`timescale 1ns/1ns
`include "stac_params.svh"
module stac_regs #(
	parameter int VLAN_DEPTH  = 4096,
	parameter int VLAN_IDX_W  = 12,
	parameter int VLAN_DATA_W = 22
) (
	input  wire logic                   clk_in,
	input  wire logic                   reset_in,
	input  wire logic [7:0]             reg_addr_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	input  wire logic [7:0]             reg_wdata_in,
	output logic      [7:0]             reg_rdata_out,
	output logic                        reg_rvalid_out,
	output logic                        search_start_out,
	input  wire logic                   search_done_in,
	output logic                        search_take_out,
	input  wire logic                   found_push_in,
	input  wire logic                   found_entry_valid_in,
	input  wire logic                   found_entry_static_in,
	input  wire logic                   found_entry_age_in,
	input  wire logic [2:0]             found_entry_traffic_class_in,
	input  wire logic [8:0]             group_forward_ports_in,
	input  wire logic [11:0]            found_entry_vlan_id_in,
	input  wire logic [47:0]            found_entry_mac_in,
	input  wire logic [VLAN_DATA_W-1:0] vlan_wdata_in,
	output logic      [VLAN_DATA_W-1:0] vlan_rdata_out
);
	// ------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------
	function automatic logic in_rng(input logic [7:0] a,
		input logic [7:0] base, input logic [3:0] n);
		return ({1'b0, a} >= {1'b0, base}) &&
			({1'b0, a} < ({1'b0, base} + {5'h00, n}));
	endfunction

	function automatic logic [7:0] res_base(input int i);
		return (i == 0) ? `STAC_OFF_RESULT0 : `STAC_OFF_RESULT1;
	endfunction

	function automatic logic [7:0] mv_base(input int i);
		return (i == 0) ? `STAC_OFF_MACVID0 : `STAC_OFF_MACVID1;
	endfunction

	function automatic logic [31:0] pack_entry(input logic v,
		input logic st, input logic ag, input logic [2:0] tc,
		input logic [8:0] ports, input logic mcast);
		logic [31:0] w;
		w = '0;
		w[`STAC_VALID_BIT] = v;                         // RULE2
		w[`STAC_STATIC_BIT] = st;                       // RULE3
		w[`STAC_AGE_BIT] = ag;                          // RULE4
		w[`STAC_TC_HI:`STAC_TC_LO] = tc;                // RULE5
		if (mcast)
			w[`STAC_MAP_HI:0] = ports;                  // RULE7
		else
			w[`STAC_PORT_HI:0] = ports[`STAC_PORT_HI:0]; // RULE8
		return w;
	endfunction

	// ------------------------------------------------------------------
	// Search result slots
	// ------------------------------------------------------------------
	logic [1:0]  full_reg, full_next;
	logic [31:0] data_reg [2];
	logic [31:0] data_next [2];
	logic [63:0] macvid_reg [2];
	logic [63:0] macvid_next [2];
	logic        run_reg, run_next;
	logic        start_reg, start_next;
	logic        take_reg, take_next;
	logic        slot_sel;
	logic        ctrl_start_wr;

	assign ctrl_start_wr = reg_wr_in && reg_wdata_in[`STAC_GO_BIT] &&
		(reg_addr_in == `STAC_OFF_SRCH_CTRL);

	always_comb
	begin
		full_next = full_reg;
		data_next = data_reg;
		macvid_next = macvid_reg;
		run_next = run_reg;
		start_next = 1'b0;
		// Top byte read ends a slot; software reads bytes low to high
		for (int i = 0; i < 2; i++)
		begin
			if (reg_rd_in && reg_addr_in == res_base(i) + `STAC_TOP_BYTE)
			begin
				full_next[i] = 1'b0;                    // RULE6
				data_next[i] = '0;                      // RULE6
			end
		end
		// Engine only offers while take_reg is high, so slot_sel is empty
		slot_sel = full_reg[0];
		if (found_push_in && take_reg)
		begin
			full_next[slot_sel] = 1'b1;                 // RULE1
			data_next[slot_sel] = pack_entry(found_entry_valid_in,
				found_entry_static_in, found_entry_age_in,
				found_entry_traffic_class_in, group_forward_ports_in,
				found_entry_mac_in[`STAC_GROUP_BIT]);
			macvid_next[slot_sel] = '0;
			macvid_next[slot_sel][`STAC_VID_HI:`STAC_VID_LO] =
				found_entry_vlan_id_in;                 // RULE14
			macvid_next[slot_sel][`STAC_MAC_HI:0] = found_entry_mac_in;
		end
		if (search_done_in)
			run_next = 1'b0;                            // RULE12
		// A start written in the cycle the search ends still wins
		if (ctrl_start_wr && (!run_reg || search_done_in))
		begin
			run_next = 1'b1;                            // RULE12
			start_next = 1'b1;
		end
		take_next = run_next && !(&full_next);          // RULE6
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			full_reg <= '0;
			data_reg <= '{default: '0};
			macvid_reg <= '{default: '0};
			run_reg <= 1'b0;
			start_reg <= 1'b0;
			take_reg <= 1'b0;
		end
		else
		begin
			full_reg <= full_next;
			data_reg <= data_next;
			macvid_reg <= macvid_next;
			run_reg <= run_next;
			start_reg <= start_next;
			take_reg <= take_next;
		end
	end

	// ------------------------------------------------------------------
	// VLAN table command path
	// ------------------------------------------------------------------
	stac_pkg::stac_vstate_t   vstate_reg, vstate_next;
	logic                     go_reg, go_next;
	stac_pkg::stac_op_t       op_reg, op_next;
	logic [4:0]               cresv_reg, cresv_next;
	logic [VLAN_IDX_W-1:0]    idx_reg, idx_next;
	logic [VLAN_IDX_W-1:0]    clr_reg, clr_next;
	logic [VLAN_DATA_W-1:0]   vrd_reg, vrd_next;
	logic                     mem_we, mem_re;
	logic [VLAN_IDX_W-1:0]    mem_addr;
	logic [VLAN_DATA_W-1:0]   mem_wd, mem_rd;
	logic [15:0]              idx_wide;

	assign idx_wide = 16'(idx_reg);

	always_comb
	begin
		vstate_next = vstate_reg;
		go_next = go_reg;
		op_next = op_reg;
		cresv_next = cresv_reg;
		idx_next = idx_reg;
		clr_next = clr_reg;
		vrd_next = vrd_reg;
		mem_we = 1'b0;
		mem_re = 1'b0;
		mem_addr = idx_reg;                             // RULE11
		mem_wd = vlan_wdata_in;
		// Command and index are frozen while an op is in flight
		if (!go_reg && reg_wr_in)
		begin
			if (reg_addr_in == `STAC_OFF_VCMD)
			begin
				go_next = reg_wdata_in[`STAC_GO_BIT];   // RULE9
				cresv_next = reg_wdata_in[`STAC_CRESV_HI:`STAC_CRESV_LO];
				op_next = reg_wdata_in[`STAC_OP_HI:0];
			end
			if (reg_addr_in == `STAC_OFF_VIDX_LO)
				idx_next = VLAN_IDX_W'({idx_wide[15:8], reg_wdata_in});
			if (reg_addr_in == `STAC_OFF_VIDX_HI)
				idx_next = VLAN_IDX_W'({reg_wdata_in, idx_wide[7:0]});
		end
		unique case (vstate_reg)
			stac_pkg::stac_v_idle:
			begin
				if (go_reg)
				begin
					case (op_reg)                       // RULE10
						`STAC_OP_WRITE:
						begin
							mem_we = 1'b1;
							go_next = 1'b0;             // RULE9
						end
						`STAC_OP_READ:
						begin
							mem_re = 1'b1;
							vstate_next = stac_pkg::stac_v_read;
						end
						`STAC_OP_CLEAR:
						begin
							clr_next = '0;
							vstate_next = stac_pkg::stac_v_clear;
						end
						default:
							go_next = 1'b0;             // RULE16
					endcase
				end
			end
			stac_pkg::stac_v_read:
			begin
				vrd_next = mem_rd;
				go_next = 1'b0;                         // RULE9
				vstate_next = stac_pkg::stac_v_idle;
			end
			stac_pkg::stac_v_clear:
			begin
				// One entry per cycle: a full clear takes VLAN_DEPTH cycles
				mem_we = 1'b1;
				mem_addr = clr_reg;
				mem_wd = '0;
				clr_next = clr_reg + 1'b1;
				if (clr_reg == VLAN_IDX_W'(VLAN_DEPTH - 1))
				begin
					go_next = 1'b0;                     // RULE9
					vstate_next = stac_pkg::stac_v_idle;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			vstate_reg <= stac_pkg::stac_v_idle;
			go_reg <= 1'b0;
			op_reg <= `STAC_OP_WRITE;
			cresv_reg <= '0;
			idx_reg <= '0;
			clr_reg <= '0;
			vrd_reg <= '0;
		end
		else
		begin
			vstate_reg <= vstate_next;
			go_reg <= go_next;
			op_reg <= op_next;
			cresv_reg <= cresv_next;
			idx_reg <= idx_next;
			clr_reg <= clr_next;
			vrd_reg <= vrd_next;
		end
	end

	stac_vlan_mem #(
		.DEPTH (VLAN_DEPTH),
		.AW    (VLAN_IDX_W),
		.DW    (VLAN_DATA_W)
	) u_vlan_mem (
		.clk_in      (clk_in),
		.reset_in    (reset_in),
		.wr_en_in    (mem_we),
		.rd_en_in    (mem_re),
		.addr_in     (mem_addr),
		.wr_data_in  (mem_wd),
		.rd_data_out (mem_rd)
	);

	// ------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------
	logic [7:0] rdata_next;

	always_comb
	begin
		rdata_next = '0;
		if (reg_rd_in)
		begin
			if (reg_addr_in == `STAC_OFF_SRCH_CTRL)
				rdata_next = {run_reg, 6'h00, |full_reg}; // RULE13
			for (int i = 0; i < 2; i++)
			begin
				if (in_rng(reg_addr_in, res_base(i), `STAC_LEN_RESULT))
					rdata_next = data_reg[i][{reg_addr_in[1:0], 3'h0} +: 8];
				if (in_rng(reg_addr_in, mv_base(i), `STAC_LEN_MACVID))
					rdata_next = macvid_reg[i][{reg_addr_in[2:0], 3'h0} +: 8];
			end
			if (in_rng(reg_addr_in, `STAC_OFF_VCMD, `STAC_LEN_ONE))
				rdata_next = {go_reg, cresv_reg, op_reg};
			if (reg_addr_in == `STAC_OFF_VIDX_LO)
				rdata_next = idx_wide[7:0];
			if (reg_addr_in == `STAC_OFF_VIDX_HI)
				rdata_next = idx_wide[15:8];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			reg_rdata_out <= '0;
			reg_rvalid_out <= 1'b0;
		end
		else
		begin
			reg_rdata_out <= rdata_next;
			reg_rvalid_out <= reg_rd_in;
		end
	end

	assign search_start_out = start_reg;
	assign search_take_out = take_reg;
	assign vlan_rdata_out = vrd_reg;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	logic push0, push1;
	assign push0 = found_push_in && take_reg && !full_reg[0];
	assign push1 = found_push_in && take_reg && full_reg[0];

	property p_slots_indep;
		@(posedge clk_in) disable iff (reset_in)
		push1 && !reg_rd_in |=> $stable(data_reg[0]) && full_reg[1];
	endproperty
	a_slots_indep: assert property (p_slots_indep) // RULE1
		else $error("slot 0 disturbed by a fill of slot 1");

	property p_valid_pos;
		@(posedge clk_in) disable iff (reset_in)
		push0 |=> data_reg[0][16] == $past(found_entry_valid_in);
	endproperty
	a_valid_pos: assert property (p_valid_pos) // RULE2
		else $error("valid flag not in bit 16");

	property p_static_pos;
		@(posedge clk_in) disable iff (reset_in)
		push1 |=> data_reg[1][15] == $past(found_entry_static_in);
	endproperty
	a_static_pos: assert property (p_static_pos) // RULE3
		else $error("static flag not in bit 15");

	property p_age_pos;
		@(posedge clk_in) disable iff (reset_in)
		push0 |=> data_reg[0][14] == $past(found_entry_age_in);
	endproperty
	a_age_pos: assert property (p_age_pos) // RULE4
		else $error("age flag not in bit 14");

	property p_tc_pos;
		@(posedge clk_in) disable iff (reset_in)
		push0 |=> data_reg[0][13:11] == $past(found_entry_traffic_class_in);
	endproperty
	a_tc_pos: assert property (p_tc_pos) // RULE5
		else $error("traffic class not in bits 13 to 11");

	property p_read_clears;
		@(posedge clk_in) disable iff (reset_in)
		reg_rd_in && reg_addr_in == `STAC_OFF_RESULT0 + `STAC_TOP_BYTE
		&& run_reg && !found_push_in && !search_done_in
		|=> !full_reg[0] && data_reg[0] == 32'h0 && take_reg;
	endproperty
	a_read_clears: assert property (p_read_clears) // RULE6
		else $error("slot read did not clear and resume");

	property p_mcast_map;
		@(posedge clk_in) disable iff (reset_in)
		push0 && found_entry_mac_in[40]
		|=> data_reg[0][8:0] == $past(group_forward_ports_in);
	endproperty
	a_mcast_map: assert property (p_mcast_map) // RULE7
		else $error("multicast port map wrong");

	property p_ucast_port;
		@(posedge clk_in) disable iff (reset_in)
		push0 && !found_entry_mac_in[40] |=> data_reg[0][8:4] == 5'h00
		&& data_reg[0][3:0] == $past(group_forward_ports_in[3:0]);
	endproperty
	a_ucast_port: assert property (p_ucast_port) // RULE8
		else $error("unicast port number wrong");

	property p_read_done;
		@(posedge clk_in) disable iff (reset_in)
		vstate_reg == stac_pkg::stac_v_idle && go_reg && op_reg == 2'h1
		|=> go_reg ##1 !go_reg && vlan_rdata_out == $past(mem_rd);
	endproperty
	a_read_done: assert property (p_read_done) // RULE9
		else $error("read op did not finish in two cycles");

	property p_op_decode;
		@(posedge clk_in) disable iff (reset_in)
		vstate_reg == stac_pkg::stac_v_idle && go_reg && op_reg == 2'h2
		|-> !mem_we ##1 vstate_reg == stac_pkg::stac_v_clear && mem_we;
	endproperty
	a_op_decode: assert property (p_op_decode) // RULE10
		else $error("clear op not decoded");

	property p_index_used;
		@(posedge clk_in) disable iff (reset_in)
		vstate_reg == stac_pkg::stac_v_idle && go_reg && op_reg == 2'h0
		|-> mem_we && mem_addr == idx_reg ##1 !go_reg;
	endproperty
	a_index_used: assert property (p_index_used) // RULE11
		else $error("write op not at index");

	property p_search_end;
		@(posedge clk_in) disable iff (reset_in)
		search_done_in && run_reg && !ctrl_start_wr |=> !run_reg;
	endproperty
	a_search_end: assert property (p_search_end) // RULE12
		else $error("search start bit not cleared at end");

	property p_ready_flag;
		@(posedge clk_in) disable iff (reset_in)
		push0 && !reg_rd_in ##1 !reg_rd_in
		##1 reg_rd_in && reg_addr_in == `STAC_OFF_SRCH_CTRL
		|=> reg_rdata_out[`STAC_READY_BIT];
	endproperty
	a_ready_flag: assert property (p_ready_flag) // RULE13
		else $error("ready bit not set after a find");

	property p_macvid;
		@(posedge clk_in) disable iff (reset_in)
		push1 |=> macvid_reg[1][59:48] == $past(found_entry_vlan_id_in)
		&& macvid_reg[1][47:0] == $past(found_entry_mac_in);
	endproperty
	a_macvid: assert property (p_macvid) // RULE14
		else $error("companion word wrong");

	property p_resv_op;
		@(posedge clk_in) disable iff (reset_in)
		vstate_reg == stac_pkg::stac_v_idle && go_reg && op_reg == 2'h3
		|-> !mem_we ##1 !go_reg && vstate_reg == stac_pkg::stac_v_idle;
	endproperty
	a_resv_op: assert property (p_resv_op) // RULE16
		else $error("reserved op touched the table");
endmodule // stac_regs

// ---- hw/stac_vlan_mem.sv ----
// Single-port-write, single-port-read VLAN table store.
// Read data is registered: valid one edge after rd_en_in.
`timescale 1ns/1ns
module stac_vlan_mem #(
	parameter int DEPTH = 4096,
	parameter int AW    = 12,
	parameter int DW    = 22
) (
	input  wire logic          clk_in,
	input  wire logic          reset_in,
	input  wire logic          wr_en_in,
	input  wire logic          rd_en_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [DW-1:0] wr_data_in,
	output logic      [DW-1:0] rd_data_out
);
	logic [DW-1:0] mem [DEPTH];

	// Array holds no reset; the clear-table op is how software zeroes it
	always_ff @(posedge clk_in)
	begin
		if (wr_en_in)
			mem[addr_in] <= wr_data_in;
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			rd_data_out <= '0;
		else if (rd_en_in)
			rd_data_out <= mem[addr_in];
	end
endmodule // stac_vlan_mem

// ---- shared/stac_params.svh ----
// Offsets, field positions and op codes of the switch table access registers.
// Included by the register block; definitions only.
`ifndef STAC_PARAMS_SVH
`define STAC_PARAMS_SVH

// ----------------------------------------------------------------------
// Byte offsets within the register page
// ----------------------------------------------------------------------
`define STAC_OFF_SRCH_CTRL  8'h50
`define STAC_OFF_MACVID0    8'h60
`define STAC_OFF_RESULT0    8'h68
`define STAC_OFF_MACVID1    8'h70
`define STAC_OFF_RESULT1    8'h78
`define STAC_OFF_VCMD       8'h80
`define STAC_OFF_VIDX_LO    8'h81
`define STAC_OFF_VIDX_HI    8'h82
`define STAC_LEN_RESULT     4'h4
`define STAC_LEN_MACVID     4'h8
`define STAC_LEN_ONE        4'h1
`define STAC_TOP_BYTE       8'h03

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STAC_GO_BIT         7
`define STAC_READY_BIT      0
`define STAC_VALID_BIT      16
`define STAC_STATIC_BIT     15
`define STAC_AGE_BIT        14
`define STAC_TC_HI          13
`define STAC_TC_LO          11
`define STAC_MAP_HI         8
`define STAC_PORT_HI        3
`define STAC_RESV_PORT_LO   4
`define STAC_VID_HI         59
`define STAC_VID_LO         48
`define STAC_MAC_HI         47
`define STAC_GROUP_BIT      40
`define STAC_OP_HI          1
`define STAC_CRESV_HI       6
`define STAC_CRESV_LO       2

// ----------------------------------------------------------------------
// VLAN table operation codes
// ----------------------------------------------------------------------
`define STAC_OP_WRITE       2'h0
`define STAC_OP_READ        2'h1
`define STAC_OP_CLEAR       2'h2
`define STAC_OP_RESV        2'h3

`endif

// ---- shared/stac_pkg.sv ----
// Types shared by the switch table access register block.
// No assumptions beyond a SystemVerilog compiler.
package stac_pkg;
	typedef enum logic [1:0] {stac_v_idle, stac_v_read, stac_v_clear}
		stac_vstate_t;
	typedef logic [1:0] stac_op_t;
endpackage

// ---- tb/tb_stac_regs.sv ----
// Self-checking bench for the switch table access register block.
// Drives the byte register port and the search link directly; no model.
`timescale 1ns/1ns
module tb_stac_regs;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [7:0]  reg_addr_in = 8'h00;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [7:0]  reg_wdata_in = 8'h00;
	logic [7:0]  reg_rdata_out;
	logic        reg_rvalid_out;
	logic        search_start_out;
	logic        search_done_in = 1'b0;
	logic        search_take_out;
	logic        found_push_in = 1'b0;
	logic        f_valid = 1'b0;
	logic        f_static = 1'b0;
	logic        f_age = 1'b0;
	logic [2:0]  f_tc = 3'h0;
	logic [8:0]  f_ports = 9'h000;
	logic [11:0] f_vid = 12'h000;
	logic [47:0] f_mac = 48'h0;
	logic [21:0] vlan_wdata_in = 22'h0;
	logic [21:0] vlan_rdata_out;
	int          err_count = 0;
	int          checks_done = 0;
	logic [63:0] v;

	// ------------------------------------------------------------
	// Clock and device
	// ------------------------------------------------------------
	initial
	begin
		forever #10 clk_in = ~clk_in;
	end

	// Full-size table so the index readback covers all twelve bits
	stac_regs #(.VLAN_DEPTH(4096), .VLAN_IDX_W(12), .VLAN_DATA_W(22)) u_dut (
		.clk_in(clk_in), .reset_in(reset_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
		.search_start_out(search_start_out),
		.search_done_in(search_done_in),
		.search_take_out(search_take_out), .found_push_in(found_push_in),
		.found_entry_valid_in(f_valid), .found_entry_static_in(f_static),
		.found_entry_age_in(f_age), .found_entry_traffic_class_in(f_tc),
		.group_forward_ports_in(f_ports), .found_entry_vlan_id_in(f_vid),
		.found_entry_mac_in(f_mac), .vlan_wdata_in(vlan_wdata_in),
		.vlan_rdata_out(vlan_rdata_out));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	endtask

	// Lower bytes first: the top byte of a result slot empties it
	task automatic rd_n(input logic [7:0] base, input int n,
		output logic [63:0] val);
		val = 64'h0;
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk_in);
			reg_addr_in = base + 8'(i);
			reg_rd_in = 1'b1;
			@(negedge clk_in);
			chk({63'h0, reg_rvalid_out}, 64'h1);
			val[8*i +: 8] = reg_rdata_out;
			reg_rd_in = 1'b0;
		end
	endtask

	task automatic push(input logic va, input logic st, input logic ag,
		input logic [2:0] tc, input logic [8:0] p, input logic [11:0] vid,
		input logic [47:0] mac);
		@(negedge clk_in);
		{f_valid, f_static, f_age, f_tc, f_ports} = {va, st, ag, tc, p};
		{f_vid, f_mac} = {vid, mac};
		found_push_in = 1'b1;
		@(negedge clk_in);
		found_push_in = 1'b0;
	endtask

	// Polls go with a bound; a hang ends the run as a mismatch
	task automatic vop(input logic [1:0] op);
		logic [63:0] c;
		wr(8'h80, {1'b1, 5'h00, op});
		// A clear sweeps every entry, so the bound must cover the depth
		for (int i = 0; i < 2500; i++)
		begin
			rd_n(8'h80, 1, c);
			if (c[7] === 1'b0)
				return;
		end
		err_count++;
		give_verdict();
	endtask

	function automatic logic [63:0] slot_exp(logic va, logic st, logic ag,
		logic [2:0] tc, logic [8:0] p, logic mc);
		return {47'h0, va, st, ag, tc, 2'h0, mc ? p : {5'h00, p[3:0]}};
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		rd_n(8'h50, 1, v);
		chk(v, 64'h0);
		rd_n(8'h80, 3, v);
		chk(v, 64'h0);
		rd_n(8'h90, 1, v);
		chk(v, 64'h0);
		chk({search_start_out, search_take_out}, 64'h0);
		$display("test_reset done");
	endtask

	task automatic test_search();
		wr(8'h50, 8'h80);
		chk({search_start_out, search_take_out}, 64'h3);
		push(1'b1, 1'b0, 1'b1, 3'h5, 9'h1f5, 12'h123, 48'h0a00_1122_3344);
		rd_n(8'h50, 1, v);
		chk(v, 64'h81);
		push(1'b1, 1'b1, 1'b0, 3'h2, 9'h13f, 12'hfed, 48'h0b00_5566_7788);
		chk({63'h0, search_take_out}, 64'h0);
		// Refused while both slots are full
		push(1'b0, 1'b0, 1'b0, 3'h7, 9'h0ff, 12'h000, 48'h0100_0000_0000);
		rd_n(8'h50, 1, v);
		chk(v, 64'h81);
		rd_n(8'h68, 4, v);
		chk(v, slot_exp(1'b1, 1'b0, 1'b1, 3'h5, 9'h1f5, 1'b0));
		rd_n(8'h60, 8, v);
		chk(v, {4'h0, 12'h123, 48'h0a00_1122_3344});
		chk({63'h0, search_take_out}, 64'h1);
		rd_n(8'h68, 4, v);
		chk(v, 64'h0);
		rd_n(8'h78, 4, v);
		chk(v, slot_exp(1'b1, 1'b1, 1'b0, 3'h2, 9'h13f, 1'b1));
		rd_n(8'h70, 8, v);
		chk(v, {4'h0, 12'hfed, 48'h0b00_5566_7788});
		rd_n(8'h50, 1, v);
		chk(v, 64'h80);
		@(negedge clk_in);
		search_done_in = 1'b1;
		@(negedge clk_in);
		search_done_in = 1'b0;
		rd_n(8'h50, 1, v);
		chk(v, 64'h0);
		chk({63'h0, search_take_out}, 64'h0);
		$display("test_search done");
	endtask

	task automatic test_vlan();
		wr(8'h81, 8'h0a);
		wr(8'h82, 8'hf3);
		rd_n(8'h81, 2, v);
		chk(v, 64'h030a);
		vlan_wdata_in = 22'h2a5a5a;
		vop(2'h0);
		wr(8'h81, 8'h0b);
		vlan_wdata_in = 22'h15a5a5;
		vop(2'h0);
		vop(2'h1);
		chk({42'h0, vlan_rdata_out}, 64'h15a5a5);
		wr(8'h81, 8'h0a);
		vop(2'h1);
		chk({42'h0, vlan_rdata_out}, 64'h2a5a5a);
		vop(2'h3);
		vop(2'h1);
		chk({42'h0, vlan_rdata_out}, 64'h2a5a5a);
		vop(2'h2);
		vop(2'h1);
		chk({42'h0, vlan_rdata_out}, 64'h0);
		$display("test_vlan done");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (8) @(negedge clk_in);
		reset_in = 1'b0;
		test_reset();
		test_search();
		test_vlan();
		give_verdict();
	end
endmodule // tb_stac_regs
